// File: logic/tmw_timer.v
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "tmw_defs.vh"
module tmw_timer #(
  parameter CW = 16
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  output wire [1:0] s_axi_bresp_out,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  input wire [7:0] s_axi_araddr_in,
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  input wire ext_count_clock_pin_in,
  input wire [3:0] chan_io_pin_in,
  output wire [3:0] chan_io_pin_out,
  output wire [3:0] chan_io_pin_oe_n_out
);
  function [3:0] tmw_dec;
    input [7:0] a;
    begin
      case ({a[7:2], 2'b00})
        `TMW_ADDR_MODE: tmw_dec = `TMW_IX_MODE;
        `TMW_ADDR_CTRL: tmw_dec = `TMW_IX_CTRL;
        `TMW_ADDR_CNT: tmw_dec = `TMW_IX_CNT;
        `TMW_ADDR_STAT: tmw_dec = `TMW_IX_STAT;
        `TMW_ADDR_GEN_A: tmw_dec = `TMW_IX_GEN_A;
        `TMW_ADDR_GEN_B: tmw_dec = `TMW_IX_GEN_B;
        `TMW_ADDR_GEN_C: tmw_dec = `TMW_IX_GEN_C;
        `TMW_ADDR_GEN_D: tmw_dec = `TMW_IX_GEN_D;
        default: tmw_dec = `TMW_IX_NONE;
      endcase
    end
  endfunction

  function [15:0] tmw_merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      tmw_merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
      tmw_merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  // register state
  reg [7:0] mode_q;
  reg [7:0] ctrl_q;
  reg [CW-1:0] cnt_q;
  reg [`TMW_STAT_W-1:0] stat_q;
  reg [CW-1:0] gen_a_q;
  reg [CW-1:0] gen_b_q;
  reg [CW-1:0] gen_c_q;
  reg [CW-1:0] gen_d_q;

  // bus state
  reg aw_hold_q;
  reg [7:0] aw_addr_q;
  reg w_hold_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  wire wr_fire;
  wire [3:0] wr_ix;
  wire rd_fire;
  wire [3:0] rd_ix;
  wire [7:0] mode_rd;
  wire [4:0] pins_sync;
  reg ext_prev_q;
  wire ext_rise;
  wire tick;
  wire [3:0] match;
  wire [3:0] capture;
  wire [3:0] pwm_en;
  wire [3:0] chan_act;
  wire [4*CW-1:0] cmp_vec;
  wire clr_on_a;
  wire ovf;
  reg [31:0] rd_mux;

  // ---------------- AXI4-Lite write channel ----------------
  assign s_axi_awready_out = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready_out = ~w_hold_q & ~bvalid_q;
  assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_ix = tmw_dec(aw_addr_q);

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `TMW_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_ix == `TMW_IX_NONE) ? `TMW_RESP_SLVERR : `TMW_RESP_OKAY;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  // ---------------- AXI4-Lite read channel ----------------
  assign s_axi_arready_out = ~rvalid_q;
  assign rd_fire = s_axi_arvalid_in & ~rvalid_q;
  assign rd_ix = tmw_dec(s_axi_araddr_in);
  assign mode_rd = mode_q | `TMW_MODE_RSV_ONES;

  always @* begin
    case (rd_ix)
      `TMW_IX_MODE: rd_mux = {24'h000000, mode_rd};
      `TMW_IX_CTRL: rd_mux = {24'h000000, ctrl_q};
      `TMW_IX_CNT: rd_mux = {16'h0000, cnt_q};
      `TMW_IX_STAT: rd_mux = {27'h0000000, stat_q};
      `TMW_IX_GEN_A: rd_mux = {16'h0000, gen_a_q};
      `TMW_IX_GEN_B: rd_mux = {16'h0000, gen_b_q};
      `TMW_IX_GEN_C: rd_mux = {16'h0000, gen_c_q};
      `TMW_IX_GEN_D: rd_mux = {16'h0000, gen_d_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `TMW_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= (rd_ix == `TMW_IX_NONE) ? `TMW_RESP_SLVERR : `TMW_RESP_OKAY;
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // ---------------- pins and count source ----------------
  tmw_sync #(
    .W(5)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({ext_count_clock_pin_in, chan_io_pin_in}),
    .sync_out(pins_sync)
  );

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      ext_prev_q <= 1'b0;
    else
      ext_prev_q <= pins_sync[4];
  end

  assign ext_rise = pins_sync[4] & ~ext_prev_q;
  // count only while running, on every clock or on external rising edges
  assign tick = mode_q[`TMW_M_RUN] & (ctrl_q[`TMW_C_EXT] ? ext_rise : 1'b1);

  // channel a has no pwm role
  assign pwm_en = {mode_q[`TMW_M_PWM_D], mode_q[`TMW_M_PWM_C],
    mode_q[`TMW_M_PWM_B], 1'b0};
  // a register serving as buffer loses its own compare/capture
  assign chan_act = {~mode_q[`TMW_M_BUFB], ~mode_q[`TMW_M_BUFA], 2'b11};
  assign cmp_vec = {gen_d_q, gen_c_q, gen_b_q, gen_a_q};
  assign clr_on_a = ctrl_q[`TMW_C_CLR] & match[0];
  assign ovf = tick & ~clr_on_a & (cnt_q == {CW{1'b1}});

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
      tmw_chan #(
        .CW(CW)
      ) u_chan (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .tick_in(tick),
        .cnt_in(cnt_q),
        .cmp_in(cmp_vec[gi*CW +: CW]),
        .act_in(chan_act[gi]),
        .out_mode_in(ctrl_q[gi]),
        .pwm_in(pwm_en[gi]),
        .period_match_in(match[0]),
        .pin_sync_in(pins_sync[gi]),
        .match_out(match[gi]),
        .capture_out(capture[gi]),
        .pin_out(chan_io_pin_out[gi]),
        .pin_oe_n_out(chan_io_pin_oe_n_out[gi])
      );
    end
  endgenerate

  // ---------------- mode, control, status ----------------
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q <= 8'h00;
      ctrl_q <= 8'h00;
      stat_q <= {`TMW_STAT_W{1'b0}};
    end else begin
      if (wr_fire && wr_ix == `TMW_IX_MODE && w_strb_q[0])
        mode_q <= w_data_q[7:0] & `TMW_MODE_WMASK;
      if (wr_fire && wr_ix == `TMW_IX_CTRL && w_strb_q[0])
        ctrl_q <= w_data_q[7:0] & `TMW_CTRL_WMASK;
      // write-one-to-clear; a new event in the same cycle wins
      if (wr_fire && wr_ix == `TMW_IX_STAT && w_strb_q[0])
        stat_q <= (stat_q & ~w_data_q[`TMW_STAT_W-1:0]) | {ovf, match | capture};
      else
        stat_q <= stat_q | {ovf, match | capture};
    end
  end

  // ---------------- counter ----------------
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      cnt_q <= {CW{1'b0}};
    else if (wr_fire && wr_ix == `TMW_IX_CNT)
      cnt_q <= tmw_merge16(cnt_q, w_data_q, w_strb_q);
    else if (clr_on_a)
      cnt_q <= {CW{1'b0}};
    else if (tick)
      cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
  end

  // ---------------- general registers with buffer pairing ----------------
  // capture beats a software write in the same cycle
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gen_a_q <= {CW{1'b1}};
      gen_b_q <= {CW{1'b1}};
      gen_c_q <= {CW{1'b1}};
      gen_d_q <= {CW{1'b1}};
    end else begin
      if (capture[0])
        gen_a_q <= cnt_q;
      else if (match[0] && mode_q[`TMW_M_BUFA])
        gen_a_q <= gen_c_q;
      else if (wr_fire && wr_ix == `TMW_IX_GEN_A)
        gen_a_q <= tmw_merge16(gen_a_q, w_data_q, w_strb_q);

      if (capture[1])
        gen_b_q <= cnt_q;
      else if (match[1] && mode_q[`TMW_M_BUFB])
        gen_b_q <= gen_d_q;
      else if (wr_fire && wr_ix == `TMW_IX_GEN_B)
        gen_b_q <= tmw_merge16(gen_b_q, w_data_q, w_strb_q);

      if (capture[0] && mode_q[`TMW_M_BUFA])
        gen_c_q <= gen_a_q;
      else if (capture[2])
        gen_c_q <= cnt_q;
      else if (wr_fire && wr_ix == `TMW_IX_GEN_C)
        gen_c_q <= tmw_merge16(gen_c_q, w_data_q, w_strb_q);

      if (capture[1] && mode_q[`TMW_M_BUFB])
        gen_d_q <= gen_b_q;
      else if (capture[3])
        gen_d_q <= cnt_q;
      else if (wr_fire && wr_ix == `TMW_IX_GEN_D)
        gen_d_q <= tmw_merge16(gen_d_q, w_data_q, w_strb_q);
    end
  end
endmodule

// File: logic/tmw_defs.vh
`ifndef TMW_DEFS_VH
`define TMW_DEFS_VH
// register byte addresses
`define TMW_ADDR_MODE 8'h00
`define TMW_ADDR_CTRL 8'h04
`define TMW_ADDR_CNT 8'h08
`define TMW_ADDR_STAT 8'h0c
`define TMW_ADDR_GEN_A 8'h10
`define TMW_ADDR_GEN_B 8'h14
`define TMW_ADDR_GEN_C 8'h18
`define TMW_ADDR_GEN_D 8'h1c
// decoded register index
`define TMW_IX_MODE 4'h0
`define TMW_IX_CTRL 4'h1
`define TMW_IX_CNT 4'h2
`define TMW_IX_STAT 4'h3
`define TMW_IX_GEN_A 4'h4
`define TMW_IX_GEN_B 4'h5
`define TMW_IX_GEN_C 4'h6
`define TMW_IX_GEN_D 4'h7
`define TMW_IX_NONE 4'hf
// timer_mode_select fields
`define TMW_M_RUN 7
`define TMW_M_RSV_HI 6
`define TMW_M_BUFB 5
`define TMW_M_BUFA 4
`define TMW_M_RSV_LO 3
`define TMW_M_PWM_D 2
`define TMW_M_PWM_C 1
`define TMW_M_PWM_B 0
`define TMW_MODE_WMASK 8'hb7
`define TMW_MODE_RSV_ONES 8'h48
// control fields: [3:0] pin is output per channel, [4] external clock, [5] clear on match a
`define TMW_C_EXT 4
`define TMW_C_CLR 5
`define TMW_CTRL_WMASK 8'h3f
// status fields: [3:0] match/capture per channel, [4] overflow
`define TMW_S_OVF 4
`define TMW_STAT_W 5
`define TMW_RESP_OKAY 2'h0
`define TMW_RESP_SLVERR 2'h2
`endif

// File: logic/tmw_sync.v
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module tmw_sync #(
  parameter W = 5
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// File: logic/tmw_chan.v
`timescale 1ns/1ps
// one compare/capture/pwm pin channel
module tmw_chan #(
  parameter CW = 16
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire tick_in,
  input wire [CW-1:0] cnt_in,
  input wire [CW-1:0] cmp_in,
  input wire act_in,
  input wire out_mode_in,
  input wire pwm_in,
  input wire period_match_in,
  input wire pin_sync_in,
  output wire match_out,
  output wire capture_out,
  output wire pin_out,
  output wire pin_oe_n_out
);
  reg pin_prev_q;
  reg level_q;
  reg oe_n_q;
  wire drive;
  wire cap_mode;

  assign drive = out_mode_in | pwm_in;
  assign cap_mode = ~drive;
  assign match_out = act_in & drive & tick_in & (cnt_in == cmp_in);
  assign capture_out = act_in & cap_mode & pin_sync_in & ~pin_prev_q;

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_prev_q <= 1'b0;
      level_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      pin_prev_q <= pin_sync_in;
      oe_n_q <= ~drive;
      if (pwm_in) begin
        // own match ends the pulse, period match starts it
        if (match_out)
          level_q <= 1'b0;
        else if (period_match_in)
          level_q <= 1'b1;
      end else if (match_out) begin
        level_q <= ~level_q;
      end
    end
  end

  assign pin_out = level_q;
  assign pin_oe_n_out = oe_n_q;
endmodule

// File: test/tmw_pin_model.sv
`timescale 1ns/1ps
// pins as the outside world sees them: external sources and loads
module tmw_pin_model (
  input wire [3:0] drv_lvl_in,
  input wire [3:0] drv_oe_n_in,
  input wire [3:0] src_lvl_in,
  input wire pulse_req_in,
  output wire [3:0] wire_lvl_out,
  output wire ext_clk_out
);
  // a pin the device drives shows its level, otherwise the outside source
  assign wire_lvl_out = (drv_oe_n_in & src_lvl_in) | (~drv_oe_n_in & drv_lvl_in);
  assign ext_clk_out = pulse_req_in;
endmodule

// File: test/tmw_timer_chk.sv
`timescale 1ns/1ps
module tmw_timer_chk (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_rvalid_out,
  input wire [31:0] s_axi_rdata_out,
  input wire [3:0] chan_io_pin_oe_n_out
);
  reg [7:0] aa_q, wd_q, mode_q, ctrl_q;
  reg mrd_q;
  wire [3:0] oe_n = chan_io_pin_oe_n_out;
  // shadow of mode and control, updated at the write response
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aa_q <= 8'h00;
      wd_q <= 8'h00;
      mode_q <= 8'h00;
      ctrl_q <= 8'h00;
      mrd_q <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) aa_q <= s_axi_awaddr_in;
      if (s_axi_wvalid_in && s_axi_wready_out) wd_q <= s_axi_wdata_in[7:0];
      if (s_axi_bvalid_out && s_axi_bready_in && aa_q == 8'h00) mode_q <= wd_q;
      if (s_axi_bvalid_out && s_axi_bready_in && aa_q == 8'h04) ctrl_q <= wd_q;
      if (s_axi_arvalid_in && s_axi_arready_out) mrd_q <= (s_axi_araddr_in == 8'h00);
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rsv_read_one: assert property (s_axi_rvalid_out && mrd_q |->
    s_axi_rdata_out[6] && s_axi_rdata_out[3]) else $error("reserved mode bit not one");
  a_mode_readback: assert property (s_axi_rvalid_out && mrd_q |->
    s_axi_rdata_out == {24'h0, mode_q | 8'h48}) else $error("mode readback wrong");
  a_reset_idle: assert property ($rose(rst_n_in) |->
    oe_n == 4'hf && !s_axi_bvalid_out && !s_axi_rvalid_out) else $error("not idle after reset");
  a_pwm_b_drive: assert property (mode_q[0] |-> !oe_n[1])
    else $error("pwm b not driven");
  a_pwm_c_drive: assert property (mode_q[1] && !mode_q[4] |-> !oe_n[2])
    else $error("pwm c not driven");
  a_pwm_d_drive: assert property (mode_q[2] && !mode_q[5] |-> !oe_n[3])
    else $error("pwm d not driven");
  a_chan_a_role: assert property (!ctrl_q[0] |-> oe_n[0])
    else $error("pin a driven");
  a_chan_b_capture: assert property (!ctrl_q[1] && !mode_q[0] |-> oe_n[1])
    else $error("pin b driven while capture");
endmodule
bind tmw_timer tmw_timer_chk chk_u (.*);

// File: test/tb_tmw_timer.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("wrong value %s exp %h got %h", n, e, g); \
  end \
end
module tb_tmw_timer;
  reg clk, rst_n, awv, wv, arv, ext_q;
  reg [7:0] awa, ara;
  reg [31:0] wd, d;
  reg [3:0] src_q;
  reg [1:0] r;
  reg [1:0] bq;
  wire awr, wr_r, bv, arr, rv, ext_w;
  wire [1:0] br, rr;
  wire [31:0] rd_w;
  wire [3:0] pin_o, oe_n, pin_w;
  int fails, check_count;
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  tmw_timer dut_u (.sys_clk_in(clk), .rst_n_in(rst_n), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr_r), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1), .s_axi_bresp_out(br),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1), .s_axi_rdata_out(rd_w),
    .s_axi_rresp_out(rr), .ext_count_clock_pin_in(ext_w), .chan_io_pin_in(pin_w),
    .chan_io_pin_out(pin_o), .chan_io_pin_oe_n_out(oe_n));
  tmw_pin_model pin_u (.drv_lvl_in(pin_o), .drv_oe_n_in(oe_n), .src_lvl_in(src_q),
    .pulse_req_in(ext_q), .wire_lvl_out(pin_w), .ext_clk_out(ext_w));
  task report_and_stop;
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] v);
    reg done;
    done = 0;
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= v;
    while (!done) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_r) wv <= 0;
      if (bv) begin
        bq = br;
        done = 1;
      end
    end
  endtask
  task rd(input [7:0] a, output [31:0] dq, output [1:0] rq);
    reg done;
    done = 0;
    arv <= 1;
    ara <= a;
    while (!done) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv) begin
        dq = rd_w;
        rq = rr;
        done = 1;
      end
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    rd(a, d, r);
    `CHK("rdata", e, d)
  endtask
  // enable settles one clock after the register update
  task wo(input [7:0] a, input [31:0] v, input [3:0] e);
    wr(a, v);
    @(posedge clk);
    `CHK("pin_enable", e, oe_n)
  endtask
  task pulse(input int n);
    repeat (n) begin
      ext_q <= 1;
      repeat (4) @(posedge clk);
      ext_q <= 0;
      repeat (4) @(posedge clk);
    end
  endtask
  initial begin
    rst_n = 0;
    awv = 0;
    wv = 0;
    arv = 0;
    ext_q = 0;
    src_q = 0;
    awa = 0;
    ara = 0;
    wd = 0;
    bq = 0;
    fails = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rc(8'h00, 32'h48);
    wr(8'h00, 32'hff);
    `CHK("bresp", 2'h0, bq)
    rc(8'h00, 32'hff);
    wr(8'h00, 32'h00);
    rc(8'h00, 32'h48);
    rd(8'h20, d, r);
    `CHK("rresp", 2'h2, r)
    wr(8'h20, 32'h1);
    `CHK("bresp", 2'h2, bq)
    wo(8'h04, 32'h0, 4'hf);
    wo(8'h00, 32'h7, 4'h1);
    wo(8'h00, 32'h0, 4'hf);
    wo(8'h04, 32'h13, 4'hc);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h7);
    wr(8'h1c, 32'h9);
    wr(8'h00, 32'hb0);
    pulse(3);
    wr(8'h00, 32'h0);
    pulse(2);
    rc(8'h08, 32'h3);
    rc(8'h10, 32'h7);
    rc(8'h14, 32'h9);
    `CHK("pin_level", 4'h3, pin_o)
    src_q <= 4'h8;
    repeat (8) @(posedge clk);
    rc(8'h1c, 32'h3);
    // pwm on b: period from register a, pulse ends at own match
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h4);
    wr(8'h14, 32'h2);
    wr(8'h00, 32'h81);
    pulse(3);
    `CHK("pin_level", 4'h1, pin_o)
    pulse(2);
    `CHK("pin_level", 4'h2, pin_o)
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop;
  end
endmodule
